// file: rtl/ppc_pkg.sv
// Package with register map, field positions, frame carriers and timing counts.
`default_nettype none
package ppc_pkg;
	localparam logic [5:0] OFS_MAC_CTRL = 6'h00;
	localparam logic [5:0] OFS_POLICY = 6'h04;
	localparam logic [5:0] OFS_LIMIT0 = 6'h08;
	localparam logic [5:0] OFS_LIMIT7 = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	localparam logic [7:0] MAC_CTRL_RST = 8'h00;
	localparam logic [7:0] MAC_CTRL_WMASK = 8'hBF;
	localparam logic [7:0] POLICY_RST = 8'h00;
	localparam logic [7:0] POLICY_WMASK = 8'h7F;
	localparam logic [6:0] LIMIT_RST = 7'h00;
	localparam int BIT_BP_EN = 3;
	localparam int BIT_PASS_ALL = 0;
	localparam int BIT_PORT_BASED = 6;
	localparam int BIT_PPS = 5;
	localparam int BIT_RL_FC = 4;
	localparam int BIT_MODE_HI = 3;
	localparam int BIT_MODE_LO = 2;
	localparam int BIT_IFG = 1;
	localparam int BIT_PRE = 0;
	localparam logic [13:0] IFG_BYTES = 14'h000C;
	localparam logic [13:0] PRE_BYTES = 14'h0008;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0] BYTES_PER_MBIT_TICK = 8'h7D;
	localparam logic [19:0] BURST_UNITS = 20'h00800;
	typedef enum logic [1:0] {
		PPC_ALL = 2'b00,
		PPC_BMF = 2'b01,
		PPC_BM = 2'b10,
		PPC_BC = 2'b11
	} ppc_mode_t;
	typedef struct packed {
		logic [13:0] len;
		logic [2:0] prio;
		logic bcast;
		logic mcast;
		logic flood;
		logic crc_err;
		logic too_long;
		logic too_short;
		logic fc_frame;
	} ppc_frame_t;
	typedef struct packed {
		logic normal;
		logic mirror;
		logic drop;
	} ppc_verdict_t;
endpackage
`default_nettype wire

// file: rtl/ppc_port_policer.sv
// Port MAC behaviour and ingress policing with its Avalon-MM register slave.
`default_nettype none
module ppc_port_policer
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic full_duplex,
	input wire logic port_fc_en,
	input wire logic fc_filter_en,
	input wire logic rx_done,
	input wire ppc_frame_t rx_frame,
	output logic verdict_valid,
	output ppc_verdict_t verdict,
	output logic back_pressure,
	output logic flow_ctrl
);
	////////////////////////////////////////////////////////////////////////
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0] mac_ctrl_ff;
	logic [7:0] policy_ff;
	logic [6:0] pend_ff [8];
	logic [6:0] act_ff [8];
	logic [19:0] level_ff [8];
	logic [7:0] exceeded;
	logic [6:0] tick_cnt_ff;
	logic tick;
	logic wr_go;
	logic hit_limit;
	logic [2:0] lim_idx;
	logic [2:0] bkt_idx;
	logic counted;
	logic bad;
	logic fc_eff;
	logic [19:0] add_units;
	logic verdict_valid_ff;
	ppc_verdict_t verdict_ff;
	logic bp_ff;
	logic fc_ff;

	function automatic logic [2:0] lim_index(input logic [5:0] a);
		logic [5:0] d;
		d = a - OFS_LIMIT0;
		return d[4:2];
	endfunction

	function automatic logic [19:0] drain_units(input logic [6:0] code, input logic pps);
		logic [19:0] c;
		c = {13'h0000, code};
		if (pps) begin
			return c;
		end
		return 20'(c * {12'h000, BYTES_PER_MBIT_TICK});
	endfunction

	////////////////////////////////////////////////////////////////////////
	// The slave stalls each request one cycle, then answers.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign wr_go = avs_write & ack_ff;
	assign hit_limit = (avs_address >= OFS_LIMIT0) && (avs_address <= OFS_LIMIT7) && (avs_address[1:0] == 2'b00);
	assign lim_idx = lim_index(avs_address);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_ff <= 32'h00000000;
		end else if (avs_read & ~ack_ff) begin
			rdata_ff <= 32'h00000000;
			if (avs_address == OFS_MAC_CTRL) begin
				rdata_ff[7:0] <= mac_ctrl_ff;
			end else if (avs_address == OFS_POLICY) begin
				rdata_ff[7:0] <= policy_ff;
			end else if (hit_limit) begin
				rdata_ff[6:0] <= pend_ff[lim_idx];
			end else if (avs_address == OFS_STATUS) begin
				rdata_ff[9:0] <= {fc_ff, bp_ff, exceeded};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mac_ctrl_ff <= MAC_CTRL_RST;
			policy_ff <= POLICY_RST;
		end else if (wr_go) begin
			if (avs_address == OFS_MAC_CTRL) begin
				mac_ctrl_ff <= avs_writedata[7:0] & MAC_CTRL_WMASK;
			end
			if (avs_address == OFS_POLICY) begin
				policy_ff <= avs_writedata[7:0] & POLICY_WMASK;
			end
		end
	end

	// Staged limits are committed as a set by the priority seven write.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) begin
				pend_ff[i] <= LIMIT_RST;
				act_ff[i] <= LIMIT_RST;
			end
		end else if (wr_go && hit_limit) begin
			pend_ff[lim_idx] <= avs_writedata[6:0];
			if (lim_idx == 3'd7) begin
				for (int i = 0; i < 7; i++) begin
					act_ff[i] <= pend_ff[i];
				end
				act_ff[7] <= avs_writedata[6:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider giving one refill tick per microsecond.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tick_cnt_ff <= 7'h00;
		end else if (tick) begin
			tick_cnt_ff <= 7'h00;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 7'h01;
		end
	end
	assign tick = (tick_cnt_ff == 7'(TICK_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Frame classification and accounting.
	always_comb begin
		unique case (ppc_mode_t'(policy_ff[BIT_MODE_HI:BIT_MODE_LO]))
			PPC_ALL: counted = 1'b1;
			PPC_BMF: counted = rx_frame.bcast | rx_frame.mcast | rx_frame.flood;
			PPC_BM: counted = rx_frame.bcast | rx_frame.mcast;
			PPC_BC: counted = rx_frame.bcast;
		endcase
	end

	always_comb begin
		add_units = 20'h00001;
		if (!policy_ff[BIT_PPS]) begin
			add_units = {6'h00, rx_frame.len};
			if (policy_ff[BIT_IFG]) begin
				add_units = add_units + {6'h00, IFG_BYTES};
			end
			if (policy_ff[BIT_PRE]) begin
				add_units = add_units + {6'h00, PRE_BYTES};
			end
		end
	end

	assign bkt_idx = policy_ff[BIT_PORT_BASED] ? 3'd0 : rx_frame.prio;
	assign bad = rx_frame.crc_err | rx_frame.too_long | rx_frame.too_short;
	assign fc_eff = policy_ff[BIT_RL_FC] & port_fc_en;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			exceeded[i] = (act_ff[i] != 7'h00) && (level_ff[i] >= BURST_UNITS);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) begin
				level_ff[i] <= 20'h00000;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				logic [19:0] lv;
				logic [19:0] dr;
				lv = level_ff[i];
				dr = drain_units(act_ff[i], policy_ff[BIT_PPS]);
				if (tick) begin
					lv = (lv > dr) ? lv - dr : 20'h00000;
				end
				if (rx_done && counted && !bad && bkt_idx == 3'(i) && act_ff[i] != 7'h00) begin
					if (!exceeded[i] || fc_eff) begin
						lv = lv + add_units;
					end
				end
				level_ff[i] <= lv;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-frame forwarding verdict.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			verdict_valid_ff <= 1'b0;
			verdict_ff <= '0;
		end else begin
			verdict_valid_ff <= rx_done;
			verdict_ff <= '0;
			if (rx_done) begin
				if (rx_frame.fc_frame && fc_filter_en) begin
					verdict_ff.drop <= 1'b1;
				end else if (bad) begin
					verdict_ff.mirror <= mac_ctrl_ff[BIT_PASS_ALL];
					verdict_ff.drop <= ~mac_ctrl_ff[BIT_PASS_ALL];
				end else if (counted && exceeded[bkt_idx] && !fc_eff) begin
					verdict_ff.drop <= 1'b1;
				end else begin
					verdict_ff.normal <= 1'b1;
				end
			end
		end
	end
	assign verdict_valid = verdict_valid_ff;
	assign verdict = verdict_ff;

	////////////////////////////////////////////////////////////////////////
	// Congestion signalling toward the link partner.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bp_ff <= 1'b0;
			fc_ff <= 1'b0;
		end else begin
			bp_ff <= mac_ctrl_ff[BIT_BP_EN] & ~full_duplex & (|exceeded);
			fc_ff <= fc_eff & (|exceeded);
		end
	end
	assign back_pressure = bp_ff;
	assign flow_ctrl = fc_ff;

	////////////////////////////////////////////////////////////////////////
	bp_half_a: assert property (@(posedge ref_clk) disable iff (reset)
		back_pressure |-> $past(mac_ctrl_ff[BIT_BP_EN]) && !$past(full_duplex))
		else $error("Back pressure outside half duplex or while disabled.");
	bp_full_a: assert property (@(posedge ref_clk) disable iff (reset)
		$past(full_duplex) |-> !back_pressure)
		else $error("Back pressure in full duplex.");
	bad_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && bad && !rx_frame.fc_frame && !mac_ctrl_ff[BIT_PASS_ALL] |=> verdict.drop && !verdict.mirror)
		else $error("Bad frame not dropped.");
	bad_mirror_a: assert property (@(posedge ref_clk) disable iff (reset)
		verdict_valid && verdict.mirror |-> !verdict.normal && $past(bad))
		else $error("Bad frame sent as normal traffic.");
	fc_filter_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && rx_frame.fc_frame && fc_filter_en |=> verdict.drop && !verdict.mirror)
		else $error("Filtered flow-control frame passed.");
	commit_a: assert property (@(posedge ref_clk) disable iff (reset)
		!(wr_go && hit_limit && lim_idx == 3'd7) |=> $stable(act_ff[2]))
		else $error("Limit applied without priority seven write.");
	rate_fc_a: assert property (@(posedge ref_clk) disable iff (reset)
		flow_ctrl |-> $past(port_fc_en) && $past(policy_ff[BIT_RL_FC]))
		else $error("Rate flow control without general enable.");
	rate_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && !bad && !rx_frame.fc_frame && counted && exceeded[bkt_idx] && !fc_eff |=> verdict.drop)
		else $error("Over-rate frame not dropped.");
	bus_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Bus answer later than one cycle.");
	bc_only_a: assert property (@(posedge ref_clk) disable iff (reset)
		policy_ff[BIT_MODE_HI:BIT_MODE_LO] == 2'b11 && !rx_frame.bcast |-> !counted)
		else $error("Non-broadcast frame counted in broadcast mode.");
	byte_count_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && bkt_idx == 3'h7 && !policy_ff[BIT_PPS] && counted && !bad && !tick && act_ff[7] != 7'h00
		&& !exceeded[7] |=> level_ff[7] == $past(level_ff[7]) + {6'h00, $past(rx_frame.len)}
		+ ($past(policy_ff[BIT_IFG]) ? {6'h00, IFG_BYTES} : 20'h00000)
		+ ($past(policy_ff[BIT_PRE]) ? {6'h00, PRE_BYTES} : 20'h00000))
		else $error("Byte accounting of a frame is wrong.");
	pps_count_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && bkt_idx == 3'h7 && policy_ff[BIT_PPS] && counted && !bad && !tick && act_ff[7] != 7'h00
		&& !exceeded[7] |=> level_ff[7] == $past(level_ff[7]) + 20'h00001)
		else $error("Packet mode did not count one frame.");
	bp_on_a: assert property (@(posedge ref_clk) disable iff (reset)
		$past(mac_ctrl_ff[BIT_BP_EN] && !full_duplex && (|exceeded)) |-> back_pressure)
		else $error("Back pressure missing in half duplex.");
	fc_on_a: assert property (@(posedge ref_clk) disable iff (reset)
		$past(fc_eff && (|exceeded)) |-> flow_ctrl)
		else $error("Rate flow control missing while exceeded.");
	fc_off_a: assert property (@(posedge ref_clk) disable iff (reset)
		!$past(policy_ff[BIT_RL_FC]) |-> !flow_ctrl)
		else $error("Flow control from rate limit while disabled.");
	rate_pass_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && !bad && !rx_frame.fc_frame && fc_eff |=> verdict.normal)
		else $error("Frame dropped while rate flow control is in effect.");
	commit7_a: assert property (@(posedge ref_clk) disable iff (reset)
		wr_go && hit_limit && lim_idx == 3'h7 |=> act_ff[7] == $past(avs_writedata[6:0]))
		else $error("Priority seven limit not applied on its write.");
	commit_all_a: assert property (@(posedge ref_clk) disable iff (reset)
		wr_go && hit_limit && lim_idx == 3'h7 |=> act_ff[2] == $past(pend_ff[2]))
		else $error("Pending limit not committed by priority seven write.");
	mirror_only_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && bad && !rx_frame.fc_frame && mac_ctrl_ff[BIT_PASS_ALL] |=> verdict.mirror && !verdict.normal)
		else $error("Bad frame not sent to mirror only.");
	verdict_one_a: assert property (@(posedge ref_clk) disable iff (reset)
		verdict_valid |-> $onehot({verdict.normal, verdict.mirror, verdict.drop}))
		else $error("Verdict is not exactly one outcome.");
	verdict_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		!verdict_valid |-> {verdict.normal, verdict.mirror, verdict.drop} == 3'h0)
		else $error("Verdict shown without valid.");
	uncounted_a: assert property (@(posedge ref_clk) disable iff (reset)
		rx_done && !counted && !bad && !rx_frame.fc_frame |=> verdict.normal)
		else $error("Uncounted frame was limited.");
endmodule
`default_nettype wire

// file: sim/ppc_link_partner.sv
// Link partner model that hands received frames to the port.
`default_nettype none
module ppc_link_partner
	import ppc_pkg::*;
(
	input wire logic ref_clk,
	output logic rx_done,
	output ppc_frame_t rx_frame
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_done = 1'b0;
		rx_frame = '0;
	end
	// One frame per call; the fields are inverted once the frame has been taken.
	task automatic send(input ppc_frame_t f);
		@(posedge ref_clk);
		rx_done <= 1'b1;
		rx_frame <= f;
		@(posedge ref_clk);
		rx_done <= 1'b0;
		rx_frame <= ~f;
	endtask
endmodule
`default_nettype wire

// file: sim/port_ingress_policing_control_tb.sv
// Self-checking bench for the port policing block.
`default_nettype none
module port_ingress_policing_control_tb
	import ppc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam ppc_verdict_t V_N = 3'b100;
	localparam ppc_verdict_t V_M = 3'b010;
	localparam ppc_verdict_t V_D = 3'b001;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic full_duplex = 1'b0;
	logic port_fc_en = 1'b0;
	logic fc_filter_en = 1'b0;
	logic rx_done;
	ppc_frame_t rx_frame;
	logic verdict_valid;
	ppc_verdict_t verdict;
	logic back_pressure;
	logic flow_ctrl;
	int error_cnt = 0;
	int checks = 0;
	always #5 ref_clk = ~ref_clk;
	ppc_port_policer dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .full_duplex(full_duplex), .port_fc_en(port_fc_en),
		.fc_filter_en(fc_filter_en), .rx_done(rx_done), .rx_frame(rx_frame), .verdict_valid(verdict_valid),
		.verdict(verdict), .back_pressure(back_pressure), .flow_ctrl(flow_ctrl));
	ppc_link_partner lp (.ref_clk(ref_clk), .rx_done(rx_done), .rx_frame(rx_frame));
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h000000, d}, q);
	endtask
	task automatic rd(input string what, input logic [5:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(what, {24'h000000, exp}, q);
	endtask
	function automatic ppc_frame_t mk(input logic [13:0] len, input logic [3:0] k);
		ppc_frame_t f;
		f = '0;
		f.len = len;
		{f.bcast, f.mcast, f.flood, f.crc_err} = k;
		return f;
	endfunction
	task automatic frm(input string what, input ppc_frame_t f, input ppc_verdict_t exp);
		lp.send(f);
		@(negedge ref_clk);
		chk("verdict_valid", 32'(1'b1), 32'(verdict_valid));
		chk(what, 32'(exp), 32'(verdict));
		@(posedge ref_clk);
	endtask
	task automatic lvl(input string what, input logic sel, input logic exp);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(what, 32'(exp), 32'(sel ? flow_ctrl : back_pressure));
		@(posedge ref_clk);
	endtask
	task automatic rst();
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk("reset outputs", 32'h00000000, 32'({verdict_valid, verdict, back_pressure, flow_ctrl}));
		@(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd("mac_ctrl reset", OFS_MAC_CTRL, 8'h00);
		rd("policy reset", OFS_POLICY, 8'h00);
		wr(OFS_MAC_CTRL, 8'hFF);
		rd("mac_ctrl access", OFS_MAC_CTRL, 8'hBF);
		wr(OFS_POLICY, 8'hFF);
		rd("policy access", OFS_POLICY, 8'h7F);
		wr(6'h3C, 8'hFF);
		rd("unmapped", 6'h3C, 8'h00);
		wr(OFS_MAC_CTRL, 8'h00);
		wr(OFS_POLICY, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_bad();
		ppc_frame_t f;
		for (int p = 0; p < 2; p++) begin
			wr(OFS_MAC_CTRL, 8'(p));
			for (int i = 1; i < 4; i++) begin
				f = mk(14'h0040, 4'h0);
				f[i] = 1'b1;
				frm("bad frame", f, (p == 1) ? V_M : V_D);
			end
			f = mk(14'h0040, 4'h0);
			f.fc_frame = 1'b1;
			fc_filter_en <= 1'b1;
			frm("fc filtered", f, V_D);
			fc_filter_en <= 1'b0;
			frm("fc passed", f, V_N);
		end
		wr(OFS_MAC_CTRL, 8'h00);
		$display("test bad frames done");
	endtask
	task automatic t_rate();
		ppc_frame_t f;
		f = mk(14'h05DC, 4'h0);
		f.prio = 3'h5;
		wr(OFS_POLICY, 8'h40);
		wr(OFS_LIMIT0, 8'h01);
		repeat (3) frm("uncommitted", f, V_N);
		wr(OFS_LIMIT7, 8'h00);
		repeat (4000) @(posedge ref_clk);
		frm("port limit 1", f, V_N);
		frm("port limit 2", f, V_N);
		frm("over limit", f, V_D);
		wr(OFS_MAC_CTRL, 8'h08);
		lvl("bp half", 1'b0, 1'b1);
		full_duplex <= 1'b1;
		lvl("bp full", 1'b0, 1'b0);
		full_duplex <= 1'b0;
		wr(OFS_MAC_CTRL, 8'h00);
		lvl("bp off", 1'b0, 1'b0);
		port_fc_en <= 1'b1;
		lvl("fc no rl", 1'b1, 1'b0);
		wr(OFS_POLICY, 8'h50);
		lvl("fc rl", 1'b1, 1'b1);
		port_fc_en <= 1'b0;
		lvl("fc port off", 1'b1, 1'b0);
		$display("test rate done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(OFS_POLICY, 8'h40 | 8'(m << 2));
			for (int c = 0; c < 4; c++) begin
				frm("mode class", mk(14'h0040, (c == 0) ? 4'h0 : 4'(1 << c)), (c >= m) ? V_D : V_N);
			end
		end
		$display("test modes done");
	endtask
	task automatic t_prio();
		ppc_frame_t f;
		f = mk(14'h0800, 4'h0);
		f.prio = 3'h2;
		rst();
		wr(OFS_LIMIT0 + 6'h08, 8'h01);
		wr(OFS_LIMIT7, 8'h00);
		frm("prio fill", f, V_N);
		frm("prio over", f, V_D);
		f.prio = 3'h3;
		frm("other prio", f, V_N);
		rd("prio status", OFS_STATUS, 8'h04);
		wr(OFS_POLICY, 8'h10);
		port_fc_en <= 1'b1;
		f.prio = 3'h2;
		frm("fc no drop", f, V_N);
		lvl("fc on", 1'b1, 1'b1);
		port_fc_en <= 1'b0;
		$display("test priority done");
	endtask
	task automatic t_acct(input string what, input logic [7:0] pol, input logic [13:0] len, input logic [7:0] st);
		ppc_frame_t f;
		f = mk(len, 4'h0);
		f.prio = 3'h7;
		rst();
		wr(OFS_POLICY, pol);
		wr(OFS_LIMIT7, 8'h01);
		frm(what, f, V_N);
		rd(what, OFS_STATUS, st);
		$display("test %s done", what);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs();
		t_bad();
		t_rate();
		t_modes();
		t_prio();
		t_acct("bytes only", 8'h00, 14'h07FF, 8'h00);
		t_acct("bytes at burst", 8'h00, 14'h0800, 8'h80);
		t_acct("gap bytes", 8'h02, 14'h07F4, 8'h80);
		t_acct("preamble bytes", 8'h01, 14'h07F8, 8'h80);
		t_acct("packet mode", 8'h23, 14'h0800, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
